// *** design/awd_pkg.sv ***
/*
  Constants and carrier types for the ADC window detector.
  Assumes a 32-bit classic Wishbone bus with byte addressing and 8-bit
  registers placed one per aligned word at four times the register index.
*/
package awd_pkg;

  // ************************************************************
  // Register indices (byte address = index * 4)
  // ************************************************************
  localparam logic [9:0] IDX_CONFIG = 10'h0C0;
  localparam logic [9:0] IDX_NEG_SELECT = 10'h0C1;
  localparam logic [9:0] IDX_STATUS = 10'h0C2;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0C3;
  localparam logic [9:0] IDX_RESULT_HIGH = 10'h0C4;
  localparam logic [9:0] IDX_RESULT_LOW = 10'h0C5;
  localparam logic [9:0] IDX_LT_HIGH = 10'h0C6;
  localparam logic [9:0] IDX_LT_LOW = 10'h0C7;
  localparam logic [9:0] IDX_GT_HIGH = 10'h0C8;
  localparam logic [9:0] IDX_GT_LOW = 10'h0C9;
  localparam int ADDR_W = 12;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_LJST_BIT = 2;
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_DIV_W = 5;
  localparam int NEG_SEL_W = 5;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_MATCH_BIT = 2;
  localparam int CODE_W = 10;
  localparam int WORD_W = 16;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0] CONFIG_RESET = 8'hF8;
  localparam logic [4:0] NEG_SEL_RESET = 5'h1F;
  localparam logic [4:0] NEG_SEL_GROUND = 5'h1F;
  localparam logic [7:0] LT_RESET = 8'h00;
  localparam logic [7:0] GT_RESET = 8'hFF;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] EVENT_MASK = 2'h3;

  // ************************************************************
  // Timing counts
  // ************************************************************
  localparam logic [3:0] CONV_SAR_CLOCKS = 4'hD;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } awd_wb_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONVERT = 3'h2,
    ST_COMPARE = 3'h4
  } awd_state_e;

endpackage : awd_pkg

// *** design/awd_window_detector.sv ***
/*
  ADC window detector: conversion sequencer, result formatting, window
  compare against less-than and greater-than limits, sticky status with
  masked level interrupt, classic Wishbone register slave.
  Assumes the analog core presents a settled code on adc_code_i at the
  end of every conversion, synchronous to clk_sys_i.
*/
// Decided for this implementation: the Wishbone register port.
// Overview of operation
// - Less-than limit high byte, read/write, index C6, resets to zero.
// - Less-than limit low byte, read/write, resets to zero.
// - Single-ended results compare as unsigned integers.
// - Limit low above high: match when strictly between the two.
// - Inverted window: match when below greater-than or above less-than.
// - Differential results and limits compare as two's complement.
// - Each conversion lasts at least 13 SAR clocks before comparison.
// - Result compared with limits after every conversion, unattended.
// - Window match flag stays set until software clears it.
// - Ground negative input gives single-ended, others differential.
`timescale 1ns/100ps
`default_nettype none

module awd_window_detector (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire awd_pkg::awd_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [awd_pkg::CODE_W-1:0] adc_code_i,
  output logic conv_busy_o,
  output logic irq_o
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0] config_q;
  logic [awd_pkg::NEG_SEL_W-1:0] neg_sel_q;
  logic [7:0] lt_high_q;
  logic [7:0] lt_low_q;
  logic [7:0] gt_high_q;
  logic [7:0] gt_low_q;
  logic [7:0] mask_q;
  logic [awd_pkg::WORD_W-1:0] result_q;
  logic done_flag_q;
  logic match_flag_q;
  awd_pkg::awd_state_e state_q;
  logic [awd_pkg::CFG_DIV_W-1:0] div_cnt_q;
  logic [3:0] sar_cnt_q;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [9:0] idx;
  logic [7:0] wr_byte;

  assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign bus_wr = bus_req & wb_req_i.we & wb_req_i.sel[0];
  assign bus_rd = bus_req & ~wb_req_i.we;
  assign idx = wb_req_i.adr[awd_pkg::ADDR_W-1:2];
  assign wr_byte = wb_req_i.dat[7:0];

  logic start_req;
  logic status_read;
  assign start_req = bus_wr && (idx == awd_pkg::IDX_STATUS) &&
    wr_byte[awd_pkg::ST_BUSY_BIT];
  assign status_read = bus_rd && (idx == awd_pkg::IDX_STATUS);

  // ************************************************************
  // Mode, justification and limit words
  // ************************************************************
  logic diff_mode;
  logic left_justify_select;
  logic [awd_pkg::WORD_W-1:0] less_than_limit_word;
  logic [awd_pkg::WORD_W-1:0] greater_than_limit_word;
  logic [awd_pkg::CFG_DIV_W-1:0] sar_div;

  assign diff_mode = (neg_sel_q != awd_pkg::NEG_SEL_GROUND);
  assign left_justify_select = config_q[awd_pkg::CFG_LJST_BIT];
  assign sar_div = config_q[awd_pkg::CFG_DIV_LSB +: awd_pkg::CFG_DIV_W];
  assign less_than_limit_word = {lt_high_q, lt_low_q};
  assign greater_than_limit_word = {gt_high_q, gt_low_q};

  // ************************************************************
  // Result formatting
  // ************************************************************
  // Sign extension only in differential mode, so single-ended codes
  // above mid-scale still read back as positive numbers.
  logic [awd_pkg::WORD_W-1:0] code_word;
  logic ext_bit;
  assign ext_bit = diff_mode & adc_code_i[awd_pkg::CODE_W-1];
  always_comb begin
    if (left_justify_select) begin
      code_word = {adc_code_i, 6'h00};
    end else begin
      code_word = {{6{ext_bit}}, adc_code_i};
    end
  end

  // ************************************************************
  // Window compare
  // ************************************************************
  function automatic logic awd_less(input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic signed_cmp);
    if (signed_cmp) begin
      awd_less = $signed(a) < $signed(b);
    end else begin
      awd_less = a < b;
    end
  endfunction : awd_less

  logic res_gt_low;
  logic res_lt_high;
  logic lt_above_gt;
  logic window_hit;

  // Whole 16-bit words are compared, so limits must share the
  // justification of the result
  assign res_gt_low = awd_less(greater_than_limit_word, result_q,
    diff_mode);
  assign res_lt_high = awd_less(result_q, less_than_limit_word,
    diff_mode);
  assign lt_above_gt = awd_less(greater_than_limit_word,
    less_than_limit_word, diff_mode);

  always_comb begin
    if (lt_above_gt) begin
      window_hit = res_gt_low & res_lt_high;
    end else begin
      window_hit = awd_less(result_q, greater_than_limit_word, diff_mode) |
        awd_less(less_than_limit_word, result_q, diff_mode);
    end
  end

  // ************************************************************
  // SAR clock divider
  // ************************************************************
  logic sar_tick;
  assign sar_tick = (state_q == awd_pkg::ST_CONVERT) &&
    (div_cnt_q == sar_div);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_cnt_q <= '0;
    end else if (state_q != awd_pkg::ST_CONVERT || sar_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  logic conv_end;
  assign conv_end = sar_tick && (sar_cnt_q == awd_pkg::CONV_SAR_CLOCKS - 4'h1);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= awd_pkg::ST_IDLE;
    end else begin
      case (state_q)
        awd_pkg::ST_IDLE: begin
          if (start_req) begin
            state_q <= awd_pkg::ST_CONVERT;
          end
        end
        awd_pkg::ST_CONVERT: begin
          if (conv_end) begin
            state_q <= awd_pkg::ST_COMPARE;
          end
        end
        awd_pkg::ST_COMPARE: begin
          state_q <= awd_pkg::ST_IDLE;
        end
        default: begin
          state_q <= awd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sar_cnt_q <= '0;
    end else if (state_q != awd_pkg::ST_CONVERT) begin
      sar_cnt_q <= '0;
    end else if (sar_tick) begin
      sar_cnt_q <= sar_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      result_q <= '0;
    end else if (conv_end) begin
      result_q <= code_word;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      conv_busy_o <= 1'b0;
    end else begin
      conv_busy_o <= (state_q == awd_pkg::ST_CONVERT) && !conv_end;
    end
  end

  // ************************************************************
  // Sticky flags
  // ************************************************************
  // A new event beats the clear-on-read in the same cycle.
  logic match_event;
  assign match_event = (state_q == awd_pkg::ST_COMPARE) && window_hit;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      match_flag_q <= 1'b0;
    end else if (match_event) begin
      match_flag_q <= 1'b1;
    end else if (status_read) begin
      match_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      done_flag_q <= 1'b0;
    end else if (state_q == awd_pkg::ST_COMPARE) begin
      done_flag_q <= 1'b1;
    end else if (status_read) begin
      done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |({match_flag_q, done_flag_q} &
        mask_q[awd_pkg::ST_MATCH_BIT:awd_pkg::ST_DONE_BIT]);
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lt_high_q <= awd_pkg::LT_RESET;
      lt_low_q <= awd_pkg::LT_RESET;
    end else if (bus_wr && idx == awd_pkg::IDX_LT_HIGH) begin
      lt_high_q <= wr_byte;
    end else if (bus_wr && idx == awd_pkg::IDX_LT_LOW) begin
      lt_low_q <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gt_high_q <= awd_pkg::GT_RESET;
      gt_low_q <= awd_pkg::GT_RESET;
    end else if (bus_wr && idx == awd_pkg::IDX_GT_HIGH) begin
      gt_high_q <= wr_byte;
    end else if (bus_wr && idx == awd_pkg::IDX_GT_LOW) begin
      gt_low_q <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      config_q <= awd_pkg::CONFIG_RESET;
      neg_sel_q <= awd_pkg::NEG_SEL_RESET;
      mask_q <= awd_pkg::MASK_RESET;
    end else if (bus_wr) begin
      if (idx == awd_pkg::IDX_CONFIG) begin
        config_q <= {wr_byte[7:2], 2'h0};
      end
      if (idx == awd_pkg::IDX_NEG_SELECT) begin
        neg_sel_q <= wr_byte[awd_pkg::NEG_SEL_W-1:0];
      end
      if (idx == awd_pkg::IDX_IRQ_MASK) begin
        mask_q <= {5'h00, wr_byte[awd_pkg::ST_MATCH_BIT:awd_pkg::ST_DONE_BIT],
          1'b0};
      end
    end
  end

  // ************************************************************
  // Read mux and acknowledge
  // ************************************************************
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      awd_pkg::IDX_CONFIG: rd_byte = config_q;
      awd_pkg::IDX_NEG_SELECT: rd_byte = {3'h0, neg_sel_q};
      awd_pkg::IDX_STATUS: rd_byte = {5'h00, match_flag_q, done_flag_q,
        state_q == awd_pkg::ST_CONVERT};
      awd_pkg::IDX_IRQ_MASK: rd_byte = mask_q;
      awd_pkg::IDX_RESULT_HIGH: rd_byte = result_q[15:8];
      awd_pkg::IDX_RESULT_LOW: rd_byte = result_q[7:0];
      awd_pkg::IDX_LT_HIGH: rd_byte = lt_high_q;
      awd_pkg::IDX_LT_LOW: rd_byte = lt_low_q;
      awd_pkg::IDX_GT_HIGH: rd_byte = gt_high_q;
      awd_pkg::IDX_GT_LOW: rd_byte = gt_low_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // Unmapped addresses still acknowledge, reading zero, so a stray
  // access never hangs the bus.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_compare_hit;
    (state_q == awd_pkg::ST_COMPARE) && window_hit;
  endsequence

  sequence s_flag_held;
    match_flag_q ##1 match_flag_q;
  endsequence

  a_lt_reset_zero: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> (lt_high_q == 8'h00))
    else $error("Less-than high byte not cleared by reset");

  a_lt_low_write: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (bus_wr && idx == awd_pkg::IDX_LT_LOW) |=>
      (lt_low_q == $past(wr_byte)))
    else $error("Less-than low byte write lost");

  a_conv_min_length: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    $rose(state_q == awd_pkg::ST_COMPARE) |->
      $past(sar_cnt_q) == awd_pkg::CONV_SAR_CLOCKS - 4'h1 &&
      $past(sar_tick))
    else $error("Conversion ended before thirteen SAR clocks");

  // Cycles spent converting, kept for the length check only
  logic [8:0] conv_len_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || state_q == awd_pkg::ST_IDLE) begin
      conv_len_q <= '0;
    end else if (state_q == awd_pkg::ST_CONVERT) begin
      conv_len_q <= conv_len_q + 9'h001;
    end
  end

  a_start_to_compare: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_q == awd_pkg::ST_IDLE && start_req && sar_div == 5'h00) |=>
      ##13 (state_q == awd_pkg::ST_COMPARE &&
      conv_len_q == 9'(awd_pkg::CONV_SAR_CLOCKS)))
    else $error("Conversion with divider zero not thirteen cycles");

  a_hit_sets_flag: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    s_compare_hit |=> match_flag_q)
    else $error("Window hit did not set match flag");

  a_flag_sticky: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (match_flag_q && !status_read) ##1 !status_read |-> s_flag_held)
    else $error("Match flag dropped without a status read");

  a_signed_minus_one: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (diff_mode && greater_than_limit_word == 16'hFFFF &&
     result_q == 16'h0000) |-> res_gt_low)
    else $error("All-ones limit not treated as minus one");

  a_unsigned_order: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (!diff_mode && result_q == 16'hFFC0 &&
     greater_than_limit_word == 16'h1000) |-> res_gt_low)
    else $error("Single-ended compare not unsigned");

  a_mode_select: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (bus_wr && idx == awd_pkg::IDX_NEG_SELECT) |=>
      (diff_mode == ($past(wr_byte[4:0]) != 5'h1F)))
    else $error("Mode does not follow negative input select");

  a_irq_masked: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (match_flag_q && mask_q[awd_pkg::ST_MATCH_BIT]) |=> irq_o)
    else $error("Unmasked match did not raise interrupt");

  a_ack_single: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held longer than one cycle");

endmodule : awd_window_detector

`default_nettype wire

// *** tb/awd_window_detector_tb.sv ***
/*
  Self-checking bench for the ADC window detector: register reset values
  and access, window compare in every mode, sticky flags and interrupt.
  Assumes awd_pkg and awd_window_detector are compiled beforehand.
*/
`timescale 1ns/100ps
`default_nettype none

module awd_window_detector_tb;

  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  awd_pkg::awd_wb_req_s req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [9:0] adc_code = 10'h000;
  logic conv_busy_o;
  logic irq_o;
  int miscompares = 0;
  int n_tests = 0;
  int div = 31;
  bit diff = 1'b0;
  bit ljst = 1'b0;
  bit st_match = 1'b0;
  bit st_done = 1'b0;
  logic [15:0] lt_w = 16'h0000;
  logic [15:0] gt_w = 16'hFFFF;
  logic [7:0] mask = 8'h00;
  logic [9:0] cs [5];

  awd_window_detector awd_window_detector_inst (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wb_req_i(req),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .adc_code_i(adc_code),
    .conv_busy_o(conv_busy_o),
    .irq_o(irq_o)
  );

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Classic single cycle; the wait is bounded, never assumed
  task automatic bus(input logic [9:0] idx, input logic we,
                     input logic [7:0] wd, output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= we;
    req.adr <= {idx, 2'b00};
    req.sel <= 4'hF;
    req.dat <= {24'h000000, wd};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    check(16'(n < 50), 16'h0001, "bus answer");
    check(16'(wb_dat_o[31:8] != 24'h000000), 16'h0000, "dat upper bits");
    rdata = wb_dat_o[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    req.we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    bus(idx, 1'b1, d, unused);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    bus(idx, 1'b0, 8'h00, d);
    check({8'h00, d}, {8'h00, exp}, $sformatf("reg %h", idx));
  endtask : rdc

  // ************************************************************
  // Reference model
  // ************************************************************
  function automatic logic [15:0] fmt(input logic [9:0] c);
    if (ljst) return {c, 6'h00};
    return diff ? {{6{c[9]}}, c} : {6'h00, c};
  endfunction : fmt

  function automatic bit model_match(input logic [9:0] c);
    int v;
    int l;
    int g;
    v = diff ? int'($signed(fmt(c))) : int'(fmt(c));
    l = diff ? int'($signed(lt_w)) : int'(lt_w);
    g = diff ? int'($signed(gt_w)) : int'(gt_w);
    if (l > g) return (v > g) && (v < l);
    return (v < g) || (v > l);
  endfunction : model_match

  task automatic set_mode(input logic [4:0] neg, input logic [7:0] cfg);
    wr(awd_pkg::IDX_NEG_SELECT, {3'h0, neg});
    wr(awd_pkg::IDX_CONFIG, cfg);
    diff = (neg != awd_pkg::NEG_SEL_GROUND);
    ljst = cfg[2];
    div = int'(cfg[7:3]);
  endtask : set_mode

  task automatic set_lim(input logic [15:0] lt, input logic [15:0] gt);
    wr(awd_pkg::IDX_LT_HIGH, lt[15:8]);
    wr(awd_pkg::IDX_LT_LOW, lt[7:0]);
    wr(awd_pkg::IDX_GT_HIGH, gt[15:8]);
    wr(awd_pkg::IDX_GT_LOW, gt[7:0]);
    lt_w = lt;
    gt_w = gt;
  endtask : set_lim

  task automatic convert(input logic [9:0] c);
    int n;
    logic [15:0] r;
    n = 0;
    adc_code <= c;
    wr(awd_pkg::IDX_STATUS, 8'h01);
    while (conv_busy_o !== 1'b1 && n < 4) begin
      @(posedge clk_sys_i);
      n++;
    end
    while (conv_busy_o !== 1'b0 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    // Counted from the ack edge, one after the taking edge
    check(16'(n >= 13 * (div + 1) - 1 && n < 2000), 16'h0001, "conv");
    repeat (3) @(posedge clk_sys_i);
    st_done = 1'b1;
    st_match = st_match | model_match(c);
    check(16'(irq_o), 16'(|(mask[2:1] & {st_match, st_done})), "irq");
    r = fmt(c);
    rdc(awd_pkg::IDX_RESULT_HIGH, r[15:8]);
    rdc(awd_pkg::IDX_RESULT_LOW, r[7:0]);
  endtask : convert

  task automatic status_chk();
    rdc(awd_pkg::IDX_STATUS, {5'h00, st_match, st_done, 1'b0});
    st_match = 1'b0;
    st_done = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check(16'(irq_o), 16'h0000, "irq after clear");
  endtask : status_chk

  task automatic run5(input logic [15:0] lt, input logic [15:0] gt);
    set_lim(lt, gt);
    for (int i = 0; i < 5; i++) begin
      convert(cs[i]);
      status_chk();
    end
  endtask : run5

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [9:0] ri [9];
    logic [7:0] rv [9];
    logic [7:0] b;
    void'($urandom(32'h36A2));
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    ri = '{10'h0C6, 10'h0C7, 10'h0C8, 10'h0C9, 10'h0C0, 10'h0C1, 10'h0C3,
           10'h0C2, 10'h0D0};
    rv = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hF8, 8'h1F, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rdc(ri[i], rv[i]);
    $display("test reset values done");
    b = 8'($urandom);
    wr(awd_pkg::IDX_LT_HIGH, b);
    rdc(awd_pkg::IDX_LT_HIGH, b);
    b = 8'($urandom);
    wr(awd_pkg::IDX_LT_LOW, b);
    rdc(awd_pkg::IDX_LT_LOW, b);
    wr(awd_pkg::IDX_RESULT_HIGH, 8'hAA);
    rdc(awd_pkg::IDX_RESULT_HIGH, 8'h00);
    wr(10'h0D0, 8'h55);
    rdc(10'h0D0, 8'h00);
    $display("test register access done");
    mask = 8'h04;
    wr(awd_pkg::IDX_IRQ_MASK, mask);
    set_mode(5'h1F, 8'h00);
    cs = '{10'h040, 10'h041, 10'h07F, 10'h080, 10'h3FF};
    run5(16'h0080, 16'h0040);
    run5(16'h0040, 16'h0080);
    $display("test single-ended window done");
    set_mode(5'h00, 8'h00);
    cs = '{10'h3FF, 10'h000, 10'h03F, 10'h040, 10'h200};
    run5(16'h0040, 16'hFFFF);
    run5(16'hFFFF, 16'h0040);
    $display("test differential window done");
    set_mode(5'h1F, 8'h04);
    cs = '{10'h040, 10'h041, 10'h07F, 10'h080, 10'h3FF};
    run5(16'h2000, 16'h1000);
    $display("test left justified done");
    // Match then miss without a status read: flag must survive
    mask = 8'h06;
    wr(awd_pkg::IDX_IRQ_MASK, mask);
    set_mode(5'h1F, 8'h08);
    set_lim(16'h0080, 16'h0040);
    convert(10'h050);
    convert(10'h000);
    status_chk();
    $display("test sticky flag done");
    for (int k = 0; k < 12; k++) begin
      mask = {5'h00, 2'($urandom), 1'b0};
      wr(awd_pkg::IDX_IRQ_MASK, mask);
      set_mode(($urandom & 1) ? 5'h1F : 5'($urandom), {5'h00, 1'($urandom), 2'h0});
      cs[0] = 10'($urandom);
      set_lim(16'($urandom), 16'($urandom));
      convert(cs[0]);
      status_chk();
    end
    $display("test random windows done");
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

endmodule : awd_window_detector_tb

`default_nettype wire
